/* File: logic/tuner_pkg.sv */
// Shared constants and carrier types for the tuner and wideband summer
`default_nettype none
package tuner_pkg;

	// ----------------------------------------------------------------
	// Widths and sizes
	// ----------------------------------------------------------------
	localparam int NUM_CH = 4;
	localparam int ACC_W = 32;
	localparam int ANGLE_W = 18;
	localparam int SMP_W = 16;
	localparam int WB_W = 18;
	localparam int SUM_W = 21;
	localparam int FIFO_DEPTH = 8;
	localparam int HOLD_W = 16;

	// ----------------------------------------------------------------
	// Register locations (channel page and summation page)
	// ----------------------------------------------------------------
	localparam logic [3:0] SUM_CTRL_ADDR = 4'h0;
	localparam logic [3:0] SUM_STATUS_ADDR = 4'h1;
	localparam logic [3:0] CH_CTRL_ADDR = 4'h1;
	localparam logic [3:0] CH_FREQ_ADDR = 4'h2;
	localparam logic [3:0] CH_FREQ_HOLD_ADDR = 4'h3;
	localparam logic [3:0] CH_PHASE_ADDR = 4'h4;
	localparam logic [3:0] CH_PHASE_HOLD_ADDR = 4'h5;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_SCALE_LSB = 0;
	localparam int CTRL_CLR_ON_SYNC = 2;
	localparam int CTRL_PHASE_DITHER = 3;
	localparam int CTRL_AMP_DITHER = 4;
	localparam int SUM_CLIP_EN = 0;
	localparam int SUM_TWOS = 1;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] SUM_RESET = 8'h00;
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	localparam logic [ACC_W-1:0] ACC_RESET = 32'h0000_0000;
	localparam logic [HOLD_W-1:0] HOLD_DONE = 16'h0001;
	localparam logic [HOLD_W-1:0] HOLD_NONE = 16'h0000;
	localparam int MIX_SHIFT = 16;

	// ----------------------------------------------------------------
	// Clip limits and saturated codes
	// ----------------------------------------------------------------
	localparam logic signed [SUM_W-1:0] CLIP_HI = 21'sh0FFFF;
	localparam logic signed [SUM_W-1:0] CLIP_LO = -21'sh10000;
	localparam logic [WB_W-1:0] TWOS_POS_SAT = 18'h0FFFF;
	localparam logic [WB_W-1:0] TWOS_NEG_SAT = 18'h10000;
	localparam logic [WB_W-1:0] OFFS_POS_SAT = 18'h1FFFF;
	localparam logic [WB_W-1:0] OFFS_NEG_SAT = 18'h00000;
	localparam logic [WB_W-1:0] OFFS_FLIP_CLIP = 18'h10000;
	localparam logic [WB_W-1:0] OFFS_FLIP_WRAP = 18'h20000;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic signed [SMP_W-1:0] i;
		logic signed [SMP_W-1:0] q;
	} iq_t;

	typedef struct packed {
		iq_t [NUM_CH-1:0] ch;
	} bb_word_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic sum_page;
		logic [1:0] chan;
		logic [3:0] addr;
		logic [31:0] data;
	} reg_cmd_t;

endpackage
`default_nettype wire

/* File: logic/tuner_summer.sv */
// Four channel oscillator tuners, wideband summer and baseband input FIFO
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Baseband FIFO
// ----------------------------------------------------------------
module bb_fifo #(
	parameter int WIDTH = 128,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	// Honest flags straight from the count
	assign in_ready = (cnt_q != (AW + 1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem[rp_q];

	// Storage has no reset; only the pointers and the count matter
	always_ff @(posedge mclk)
	begin
		if (push)
			mem[wp_q] <= in_data;
	end

	// Pointers wrap on depth, not on power of two
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
			if (pop)
				rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
			cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule

// Behaviour
// - Each channel has a 32-bit quadrature oscillator and mixer feeding the summer.
// - IF equals oscillator rate times frequency word over two to the 32.
// - Complex mode steps the oscillator every second clock, half the clock rate.
// - Real mode steps every clock and drops the quadrature product.
// - Control bit 3 adds random phase dither below the angle bits.
// - Only the top 18 accumulator bits drive the angle to sine conversion.
// - Control bit 4 adds amplitude dither before mixer truncation.
// - The 16-bit phase offset adds to the accumulator, pi/32768 per step.
// - Frequency and phase updates each wait on their own 16-bit hold-off counter.
// - Control bit 2 clears the oscillator phase on a sync event.
// - Control bits 1..0 scale the mixer output by -6 to -24 dB.
// - Summer adds four channels to the wideband input each clock edge.
// - Output bus is released while the drive-disable input is high.
// - Summation bit 1 picks two's complement, else offset binary output.
// - Summation bit 0 enables clipping with bit 17 as guard bit.
// - Two's complement clipping saturates to 0x0FFFF and 0x10000.
// - Offset binary clipping saturates to 0x1FFFF and 0x00000.
// - Wideband input is always read as 18-bit two's complement.
// - Wideband input reaches the output sum exactly two clocks later.
// - Quad flag input low means real samples and quad flag output low.
// - Complex output interleaves I with flag low and Q with flag high.
// - A toggling quad flag input sets the I/Q sequencing of the device.
module tuner_summer (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Register port
	input wire tuner_pkg::reg_cmd_t reg_cmd,
	output logic [31:0] reg_rdata,
	// Sync pin
	input wire logic sync_in,
	// Baseband samples in
	input wire logic bb_valid,
	output logic bb_ready,
	input wire tuner_pkg::bb_word_t bb_data,
	// Wideband cascade in
	input wire logic [tuner_pkg::WB_W-1:0] wb_in,
	input wire logic quad_flag_in,
	// Wideband cascade out
	input wire logic bus_drive_disable,
	output logic [tuner_pkg::WB_W-1:0] wb_out,
	output logic wb_out_en,
	output logic quad_flag_out
);
	// ----------------------------------------------------------------
	// Register decode helpers
	// ----------------------------------------------------------------
	function automatic logic ch_hit(input tuner_pkg::reg_cmd_t c, input int ch,
		input logic [3:0] a);
		return c.wr & ~c.sum_page & (c.chan == 2'(ch)) & (c.addr == a);
	endfunction

	// Parabolic sine of an 18-bit angle; peak spurs are set by the parabola
	function automatic logic signed [15:0] sine18(input logic [17:0] p);
		logic [16:0] x;
		logic [17:0] c;
		logic [35:0] pr;
		logic [15:0] m;
		x = p[16:0];
		c = 18'h20000 - {1'b0, x};
		pr = {19'h0_0000, x} * {18'h0_0000, c};
		m = (pr[35:17] > 19'h07FFF) ? 16'h7FFF : pr[32:17];
		return p[17] ? -$signed(m) : $signed(m);
	endfunction

	// ----------------------------------------------------------------
	// Quad flag sequencing
	// ----------------------------------------------------------------
	logic qin_last_q;
	logic flag_last_q;
	logic [15:0] lfsr_q;
	wire cplx = quad_flag_in | qin_last_q;
	wire qin_toggling = quad_flag_in ^ qin_last_q;
	wire cur_q = cplx & (qin_toggling ? quad_flag_in : ~flag_last_q);
	wire osc_tick = ~cplx | cur_q;
	wire lfsr_fb = lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10];

	// Phase tracker and shared dither source
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			qin_last_q <= 1'b0;
			flag_last_q <= 1'b0;
			lfsr_q <= tuner_pkg::LFSR_SEED;
		end
		else
		begin
			qin_last_q <= quad_flag_in;
			flag_last_q <= cur_q;
			lfsr_q <= {lfsr_q[14:0], lfsr_fb};
		end
	end

	// ----------------------------------------------------------------
	// Baseband FIFO and sample hold
	// ----------------------------------------------------------------
	tuner_pkg::bb_word_t fifo_out;
	tuner_pkg::bb_word_t bb_q;
	logic fifo_valid;

	bb_fifo #(
		.WIDTH($bits(tuner_pkg::bb_word_t)),
		.DEPTH(tuner_pkg::FIFO_DEPTH)
	) bb_fifo_i (
		.mclk(mclk),
		.rstn(rstn),
		.in_valid(bb_valid),
		.in_ready(bb_ready),
		.in_data(bb_data),
		.out_valid(fifo_valid),
		.out_ready(osc_tick),
		.out_data(fifo_out)
	);

	// One baseband sample per oscillator step; an empty FIFO repeats the last
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			bb_q <= '0;
		else if (osc_tick && fifo_valid)
			bb_q <= fifo_out;
	end

	// ----------------------------------------------------------------
	// Per-channel tuners
	// ----------------------------------------------------------------
	logic signed [tuner_pkg::SUM_W-1:0] ch_out [tuner_pkg::NUM_CH];
	logic [31:0] ch_rd [tuner_pkg::NUM_CH];

	for (genvar g = 0; g < tuner_pkg::NUM_CH; g++)
	begin : g_ch
		logic [7:0] ctrl_q;
		logic [31:0] freq_sh_q;
		logic [31:0] freq_q;
		logic [15:0] fhold_q;
		logic [15:0] fcnt_q;
		logic frun_q;
		logic [15:0] phs_sh_q;
		logic [15:0] phs_q;
		logic [15:0] phold_q;
		logic [15:0] pcnt_q;
		logic prun_q;
		logic [31:0] acc_q;
		logic signed [17:0] mix_i_q;
		logic signed [17:0] mix_q_q;

		// Write strobes
		wire wr_ctrl = ch_hit(reg_cmd, g, tuner_pkg::CH_CTRL_ADDR);
		wire wr_freq = ch_hit(reg_cmd, g, tuner_pkg::CH_FREQ_ADDR);
		wire wr_fhold = ch_hit(reg_cmd, g, tuner_pkg::CH_FREQ_HOLD_ADDR);
		wire wr_phs = ch_hit(reg_cmd, g, tuner_pkg::CH_PHASE_ADDR);
		wire wr_phold = ch_hit(reg_cmd, g, tuner_pkg::CH_PHASE_HOLD_ADDR);

		// Hold-off expiry; a zero hold-off value means load at write
		wire f_load = frun_q & (fcnt_q == tuner_pkg::HOLD_DONE);
		wire p_load = prun_q & (pcnt_q == tuner_pkg::HOLD_DONE);
		wire f_start = sync_in & (fhold_q != tuner_pkg::HOLD_NONE);
		wire p_start = sync_in & (phold_q != tuner_pkg::HOLD_NONE);

		// Phase angle: offset in the top half, dither below the angle bits
		wire [31:0] dith = ctrl_q[tuner_pkg::CTRL_PHASE_DITHER] ?
			{18'h0_0000, lfsr_q[13:0]} : 32'h0000_0000;
		wire [31:0] phase = acc_q + {phs_q, 16'h0000} + dith;
		wire [17:0] angle = phase[31:14];
		wire signed [15:0] sin_v = sine18(angle);
		wire signed [15:0] cos_v = sine18(angle + 18'h10000);

		// Quadrature mixer with optional amplitude dither
		wire signed [32:0] adith = ctrl_q[tuner_pkg::CTRL_AMP_DITHER] ?
			$signed({17'h0_0000, lfsr_q}) : 33'sh0_0000_0000;
		wire signed [32:0] prod_i = 33'(bb_q.ch[g].i * cos_v) - 33'(bb_q.ch[g].q * sin_v)
			+ adith;
		wire signed [32:0] prod_q = 33'(bb_q.ch[g].i * sin_v) + 33'(bb_q.ch[g].q * cos_v)
			+ adith;
		wire [2:0] shamt = 3'(ctrl_q[tuner_pkg::CTRL_SCALE_LSB +: 2]) + 3'd1;
		wire signed [32:0] sc_i = (prod_i >>> tuner_pkg::MIX_SHIFT) >>> shamt;
		wire signed [32:0] sc_q = (prod_q >>> tuner_pkg::MIX_SHIFT) >>> shamt;

		// Real mode never uses the quadrature product
		assign ch_out[g] = (cur_q & cplx) ? tuner_pkg::SUM_W'(mix_q_q)
			: tuner_pkg::SUM_W'(mix_i_q);
		assign ch_rd[g] = (reg_cmd.addr == tuner_pkg::CH_CTRL_ADDR) ? {24'h00_0000, ctrl_q} :
			(reg_cmd.addr == tuner_pkg::CH_FREQ_ADDR) ? freq_q :
			(reg_cmd.addr == tuner_pkg::CH_FREQ_HOLD_ADDR) ? {16'h0000, fhold_q} :
			(reg_cmd.addr == tuner_pkg::CH_PHASE_ADDR) ? {16'h0000, phs_q} :
			(reg_cmd.addr == tuner_pkg::CH_PHASE_HOLD_ADDR) ? {16'h0000, phold_q} :
			32'h0000_0000;

		// Control and hold-off values
		always_ff @(posedge mclk or negedge rstn)
		begin
			if (!rstn)
			begin
				ctrl_q <= tuner_pkg::CTRL_RESET;
				fhold_q <= '0;
				phold_q <= '0;
			end
			else
			begin
				if (wr_ctrl)
					ctrl_q <= reg_cmd.data[7:0];
				if (wr_fhold)
					fhold_q <= reg_cmd.data[15:0];
				if (wr_phold)
					phold_q <= reg_cmd.data[15:0];
			end
		end

		// Frequency shadow and hold-off countdown
		always_ff @(posedge mclk or negedge rstn)
		begin
			if (!rstn)
			begin
				freq_sh_q <= '0;
				freq_q <= '0;
				fcnt_q <= '0;
				frun_q <= 1'b0;
			end
			else
			begin
				if (wr_freq)
					freq_sh_q <= reg_cmd.data;
				if (wr_freq && fhold_q == tuner_pkg::HOLD_NONE)
					freq_q <= reg_cmd.data;
				else if (f_load)
					freq_q <= freq_sh_q;
				if (f_start)
					fcnt_q <= fhold_q;
				else if (frun_q)
					fcnt_q <= fcnt_q - 16'h0001;
				frun_q <= f_start | (frun_q & ~f_load);
			end
		end

		// Phase offset shadow and hold-off countdown
		always_ff @(posedge mclk or negedge rstn)
		begin
			if (!rstn)
			begin
				phs_sh_q <= '0;
				phs_q <= '0;
				pcnt_q <= '0;
				prun_q <= 1'b0;
			end
			else
			begin
				if (wr_phs)
					phs_sh_q <= reg_cmd.data[15:0];
				if (wr_phs && phold_q == tuner_pkg::HOLD_NONE)
					phs_q <= reg_cmd.data[15:0];
				else if (p_load)
					phs_q <= phs_sh_q;
				if (p_start)
					pcnt_q <= phold_q;
				else if (prun_q)
					pcnt_q <= pcnt_q - 16'h0001;
				prun_q <= p_start | (prun_q & ~p_load);
			end
		end

		// Accumulator steps once per oscillator sample at the frequency word
		always_ff @(posedge mclk or negedge rstn)
		begin
			if (!rstn)
				acc_q <= tuner_pkg::ACC_RESET;
			else if (sync_in && ctrl_q[tuner_pkg::CTRL_CLR_ON_SYNC])
				acc_q <= tuner_pkg::ACC_RESET;
			else if (osc_tick)
				acc_q <= acc_q + freq_q;
		end

		// Mixer products held for the I and Q output slots
		always_ff @(posedge mclk or negedge rstn)
		begin
			if (!rstn)
			begin
				mix_i_q <= '0;
				mix_q_q <= '0;
			end
			else
			begin
				mix_i_q <= sc_i[17:0];
				mix_q_q <= sc_q[17:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Wideband summer
	// ----------------------------------------------------------------
	logic [7:0] sum_ctrl_q;
	logic clip_seen_q;
	logic signed [tuner_pkg::SUM_W-1:0] sum1_q;
	logic flag1_q;
	logic [tuner_pkg::WB_W-1:0] out_q;
	logic quad_flag_out_q;

	// Input bus is sign extended whatever the output format
	wire signed [tuner_pkg::SUM_W-1:0] wb_ext = tuner_pkg::SUM_W'($signed(wb_in));
	wire signed [tuner_pkg::SUM_W-1:0] sum_d = ch_out[0] + ch_out[1] + ch_out[2]
		+ ch_out[3] + wb_ext;
	wire clip_en = sum_ctrl_q[tuner_pkg::SUM_CLIP_EN];
	wire twos = sum_ctrl_q[tuner_pkg::SUM_TWOS];
	wire over_hi = clip_en & (sum1_q > tuner_pkg::CLIP_HI);
	wire over_lo = clip_en & (sum1_q < tuner_pkg::CLIP_LO);

	// Clipped codes for each format, otherwise a plain wrap
	wire [tuner_pkg::WB_W-1:0] pos_sat = twos ? tuner_pkg::TWOS_POS_SAT
		: tuner_pkg::OFFS_POS_SAT;
	wire [tuner_pkg::WB_W-1:0] neg_sat = twos ? tuner_pkg::TWOS_NEG_SAT
		: tuner_pkg::OFFS_NEG_SAT;
	wire [tuner_pkg::WB_W-1:0] in_range = clip_en ? {1'b0, sum1_q[16:0]}
		: sum1_q[17:0];
	wire [tuner_pkg::WB_W-1:0] flip = twos ? '0 : (clip_en ? tuner_pkg::OFFS_FLIP_CLIP
		: tuner_pkg::OFFS_FLIP_WRAP);
	wire [tuner_pkg::WB_W-1:0] out_d = over_hi ? pos_sat : over_lo ? neg_sat
		: (in_range ^ flip);

	// Register reads; reading status clears the clip flag
	wire rd_status = reg_cmd.rd & reg_cmd.sum_page & (reg_cmd.addr == tuner_pkg::SUM_STATUS_ADDR);
	wire [31:0] sum_rd = (reg_cmd.addr == tuner_pkg::SUM_CTRL_ADDR) ? {24'h00_0000, sum_ctrl_q} :
		(reg_cmd.addr == tuner_pkg::SUM_STATUS_ADDR) ? {31'h0000_0000, clip_seen_q} :
		32'h0000_0000;
	wire [31:0] rd_d = reg_cmd.sum_page ? sum_rd : ch_rd[reg_cmd.chan];

	// Summation control, clip status and read data
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			sum_ctrl_q <= tuner_pkg::SUM_RESET;
			clip_seen_q <= 1'b0;
			reg_rdata <= '0;
		end
		else
		begin
			if (reg_cmd.wr && reg_cmd.sum_page && reg_cmd.addr == tuner_pkg::SUM_CTRL_ADDR)
				sum_ctrl_q <= reg_cmd.data[7:0];
			// A clip in the clearing cycle keeps the flag set
			clip_seen_q <= over_hi | over_lo | (clip_seen_q & ~rd_status);
			if (reg_cmd.rd)
				reg_rdata <= rd_d;
		end
	end

	// Two register stages from wideband input to output pins
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			sum1_q <= '0;
			flag1_q <= 1'b0;
			out_q <= '0;
			quad_flag_out_q <= 1'b0;
		end
		else
		begin
			sum1_q <= sum_d;
			flag1_q <= cur_q;
			out_q <= out_d;
			quad_flag_out_q <= flag1_q;
		end
	end

	// Output drive follows the disable pin directly
	assign wb_out = out_q;
	assign wb_out_en = ~bus_drive_disable;
	assign quad_flag_out = quad_flag_out_q;
endmodule

`default_nettype wire

/* File: sim/cascade_src.sv */
// Upstream cascade source model feeding the wideband input bus
`timescale 1ns/1ps
`default_nettype none
module cascade_src (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Bench control
	input wire logic [1:0] mode,
	input wire logic [17:0] sample,
	// Cascade bus toward the device
	output logic [17:0] wb_in,
	output logic quad_flag_in
);
	logic [17:0] wb_q = 18'h00000;
	logic qin_q = 1'b0;

	// Launch after each rising edge; mode 1 holds the bus at zero
	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			wb_q <= 18'h00000;
			qin_q <= 1'b0;
		end
		else
		begin
			wb_q <= (mode == 2'h1) ? 18'h00000 : sample;
			qin_q <= (mode == 2'h1) | ((mode == 2'h2) & ~qin_q);
		end
	end
	assign wb_in = wb_q;
	assign quad_flag_in = qin_q;
endmodule
`default_nettype wire

/* File: sim/tuner_summer_assertions.sv */
// Port level checker for the tuner and wideband summer
`timescale 1ns/1ps
`default_nettype none
module tuner_summer_checker (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Register port
	input wire tuner_pkg::reg_cmd_t reg_cmd,
	input wire logic [31:0] reg_rdata,
	// Wideband side
	input wire logic quad_flag_in,
	input wire logic bus_drive_disable,
	input wire logic [tuner_pkg::WB_W-1:0] wb_out,
	input wire logic wb_out_en,
	input wire logic quad_flag_out
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	// Register access decode
	wire wr_sum0 = reg_cmd.wr && reg_cmd.sum_page && reg_cmd.addr == 4'h0;
	wire rd_sum0 = reg_cmd.rd && !reg_cmd.wr && reg_cmd.sum_page && reg_cmd.addr == 4'h0;
	wire rd_unm = reg_cmd.rd && !reg_cmd.wr && reg_cmd.sum_page && reg_cmd.addr > 4'h1;
	wire wr_hold = reg_cmd.wr && !reg_cmd.sum_page && reg_cmd.addr == 4'h3;
	wire wr_freq = reg_cmd.wr && !reg_cmd.sum_page && reg_cmd.addr == 4'h2;
	wire rd_freq = reg_cmd.rd && !reg_cmd.wr && !reg_cmd.sum_page && reg_cmd.addr == 4'h2;
	logic [7:0] ctrl_q;
	logic [1:0] settle_q;
	logic [3:0] hz_q;

	// Shadow of summation control; settle count hides the pipeline after a write
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_q <= 8'h00;
			settle_q <= 2'h0;
			hz_q <= 4'hF;
		end
		else
		begin
			if (wr_sum0)
				ctrl_q <= reg_cmd.data[7:0];
			settle_q <= wr_sum0 ? 2'h0 : (settle_q == 2'h3) ? 2'h3 : settle_q + 2'h1;
			if (wr_hold)
				hz_q[reg_cmd.chan] <= (reg_cmd.data[15:0] == 16'h0000);
		end
	end

	sequence s_freq_set;
		wr_freq && hz_q[reg_cmd.chan] ##1 rd_freq && reg_cmd.chan == $past(reg_cmd.chan);
	endsequence
	sequence s_qin_steady;
		quad_flag_in [*3];
	endsequence

	a_drive_follows_pin: assert property (wb_out_en == !bus_drive_disable)
		else $error("output enable does not follow drive pin");
	a_real_flag_low: assert property (!quad_flag_in |-> ##2 !quad_flag_out)
		else $error("quad flag out high in real mode");
	a_flag_pairs_input: assert property ($changed(quad_flag_in) && $past(rstn)
		|-> ##2 quad_flag_out == $past(quad_flag_in, 2)) else $error("flag not aligned");
	a_flag_alternates: assert property (s_qin_steady |-> ##2 quad_flag_out != $past(quad_flag_out))
		else $error("complex slots do not alternate");
	a_guard_bit_clear: assert property (settle_q == 2'h3 && ctrl_q[0] |-> !wb_out[17])
		else $error("guard bit set while clipping");
	a_ctrl_read_back: assert property (rd_sum0 |=> reg_rdata[7:0] == $past(ctrl_q))
		else $error("summation control read back wrong");
	a_unmapped_zero: assert property (rd_unm |=> reg_rdata == 32'h00000000)
		else $error("unmapped read not zero");
	a_freq_direct: assert property (s_freq_set |=> reg_rdata == $past(reg_cmd.data, 2))
		else $error("frequency without hold-off not active");
endmodule

bind tuner_summer tuner_summer_checker tuner_summer_checker_i (.mclk(mclk), .rstn(rstn),
	.reg_cmd(reg_cmd), .reg_rdata(reg_rdata), .quad_flag_in(quad_flag_in),
	.bus_drive_disable(bus_drive_disable), .wb_out(wb_out), .wb_out_en(wb_out_en),
	.quad_flag_out(quad_flag_out));
`default_nettype wire

/* File: sim/tuner_summer_bench.sv */
// Self-checking bench for the tuner and wideband summer
`timescale 1ns/1ps
`default_nettype none
module tuner_summer_bench;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	tuner_pkg::reg_cmd_t reg_cmd = '0;
	logic sync_in = 1'b0;
	logic bb_valid = 1'b0;
	logic bus_drive_disable = 1'b0;
	logic [17:0] sample = 18'h00000;
	logic [1:0] mode = 2'h0;
	logic [1:0] cfg = 2'h0;
	logic mon_en = 1'b0;
	logic [31:0] reg_rdata, v, r1, r2;
	logic bb_ready, wb_out_en, quad_flag_out, quad_flag_in, qprev, q0, q1, full_seen;
	logic [17:0] wb_in, wb_out;
	logic signed [17:0] p0, p1;
	logic signed [17:0] s0, s1;
	tuner_pkg::bb_word_t bb_word = '0;
	logic [17:0] corner [5] = '{18'h1FFFF, 18'h20000, 18'h0FFFF, 18'h10000, 18'h30000};
	int fail_count = 0;
	int checks = 0;
	int seed = 32'hc90d946c;

	always #25 mclk = ~mclk;

	cascade_src cascade_src_i (.mclk(mclk), .rstn(rstn), .mode(mode), .sample(sample),
		.wb_in(wb_in), .quad_flag_in(quad_flag_in));
	// Baseband data stays zero until the tone tests, so channels add nothing before
	tuner_summer tuner_summer_i (.mclk(mclk), .rstn(rstn), .reg_cmd(reg_cmd),
		.reg_rdata(reg_rdata), .sync_in(sync_in), .bb_valid(bb_valid), .bb_ready(bb_ready),
		.bb_data(bb_word), .wb_in(wb_in), .quad_flag_in(quad_flag_in),
		.bus_drive_disable(bus_drive_disable), .wb_out(wb_out), .wb_out_en(wb_out_en),
		.quad_flag_out(quad_flag_out));

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task final_report;
		if (fail_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Output word for a sum, clip and format settings
	function logic [17:0] fmt(logic signed [17:0] x, logic c, logic t);
		logic [17:0] r;
		r = x;
		if (c)
			r = (x > 18'sh0FFFF) ? 18'h0FFFF : (x < -18'sh10000) ? 18'h10000 : {1'b0, x[16:0]};
		if (!t)
			r = r ^ (c ? 18'h10000 : 18'h20000);
		return r;
	endfunction

	function tuner_pkg::reg_cmd_t mk(logic w, logic sp, logic [1:0] ch, logic [3:0] a,
		logic [31:0] d);
		return '{w, ~w, sp, ch, a, d};
	endfunction

	task acc(input tuner_pkg::reg_cmd_t c);
		@(posedge mclk);
		reg_cmd <= c;
	endtask

	task rd(input tuner_pkg::reg_cmd_t c, output logic [31:0] x);
		acc(c);
		acc('0);
		@(negedge mclk);
		x = reg_rdata;
	endtask

	// Two signed output words within a tolerance of each other
	function logic near(int a, int b, int tol);
		return (a - b <= tol) && (b - a <= tol);
	endfunction

	// Channel 0 output for a control and phase offset, once the pipeline settles
	task tone(input logic [7:0] ctl, input logic [15:0] ph, output logic signed [17:0] s);
		acc(mk(1'b1, 1'b0, 2'h0, 4'h1, {24'h0, ctl}));
		acc(mk(1'b1, 1'b0, 2'h0, 4'h4, {16'h0, ph}));
		acc('0);
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		s = wb_out;
	endtask

	// Input history; the sum of an input shows two edges later
	always @(posedge mclk)
	begin
		p0 <= wb_in;
		p1 <= p0;
		q0 <= quad_flag_in;
		q1 <= q0;
	end

	// Settled outputs are judged mid-cycle
	always @(negedge mclk)
	begin
		if (mon_en)
		begin
			check({14'h0, wb_out}, {14'h0, fmt(p1, cfg[0], cfg[1])});
			check({31'h0, quad_flag_out}, {31'h0, mode[1] ? q1 : mode[0] & ~qprev});
			check({31'h0, wb_out_en}, {31'h0, ~bus_drive_disable});
		end
		qprev = quad_flag_out;
	end

	// Main sequence
	initial
	begin
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		for (int c = 0; c < 12; c++)
		begin
			mon_en = 1'b0;
			cfg = c[1:0];
			acc(mk(1'b1, 1'b1, 2'h0, 4'h0, {30'h0, cfg}));
			rd(mk(1'b0, 1'b1, 2'h0, 4'h0, 32'h0), v);
			check(v, {30'h0, cfg});
			mode <= 2'(c / 4);
			repeat (4) @(posedge mclk);
			mon_en = 1'b1;
			for (int n = 0; n < 40; n++)
			begin
				@(posedge mclk);
				sample <= (n % 8 == 0) ? corner[n / 8] : 18'($random(seed));
				bus_drive_disable <= 1'($random(seed));
			end
		end
		mon_en = 1'b0;
		sample <= 18'h00000;
		mode <= 2'h0;
		acc(mk(1'b1, 1'b1, 2'h0, 4'h0, 32'h0));
		rd(mk(1'b0, 1'b1, 2'h0, 4'h1, 32'h0), v);
		check(v, 32'h00000001);
		rd(mk(1'b0, 1'b1, 2'h0, 4'h1, 32'h0), v);
		check(v, 32'h00000000);
		rd(mk(1'b0, 1'b1, 2'h0, 4'h7, 32'h0), v);
		check(v, 32'h00000000);
		r1 = $random(seed);
		r2 = $random(seed);
		acc(mk(1'b1, 1'b0, 2'h1, 4'h3, 32'h0));
		acc(mk(1'b1, 1'b0, 2'h1, 4'h2, r1));
		rd(mk(1'b0, 1'b0, 2'h1, 4'h2, 32'h0), v);
		check(v, r1);
		acc(mk(1'b1, 1'b0, 2'h1, 4'h3, 32'h5));
		acc(mk(1'b1, 1'b0, 2'h1, 4'h2, r2));
		rd(mk(1'b0, 1'b0, 2'h1, 4'h2, 32'h0), v);
		check(v, r1);
		@(posedge mclk);
		sync_in <= 1'b1;
		@(posedge mclk);
		sync_in <= 1'b0;
		rd(mk(1'b0, 1'b0, 2'h1, 4'h2, 32'h0), v);
		check(v, r1);
		repeat (8) @(posedge mclk);
		rd(mk(1'b0, 1'b0, 2'h1, 4'h2, 32'h0), v);
		check(v, r2);
		// Complex mode drains every second clock, so steady pushes fill the buffer
		@(posedge mclk);
		mode <= 2'h1;
		full_seen = 1'b0;
		bb_valid <= 1'b1;
		repeat (24)
		begin
			@(negedge mclk);
			if (bb_ready === 1'b0)
				full_seen = 1'b1;
		end
		check({31'h0, full_seen}, 32'h1);
		@(posedge mclk);
		bb_valid <= 1'b0;
		repeat (24) @(negedge mclk);
		check({31'h0, bb_ready}, 32'h1);
		// One tone word on channel 0, real mode, two's complement sum without clip
		@(posedge mclk);
		mode <= 2'h0;
		bb_word.ch[0].i <= 16'sh4000;
		bb_valid <= 1'b1;
		acc(mk(1'b1, 1'b1, 2'h0, 4'h0, 32'h2));
		bb_valid <= 1'b0;
		tone(8'h00, 16'h0000, s0);
		check({31'h0, near(s0, 0, 0)}, 32'h0);
		tone(8'h01, 16'h0000, s1);
		check({31'h0, near(2 * s1, s0, 2)}, 32'h1);
		tone(8'h03, 16'h0000, s1);
		check({31'h0, near(8 * s1, s0, 8)}, 32'h1);
		tone(8'h00, 16'h8000, s1);
		check({31'h0, near(s1, -s0, 2)}, 32'h1);
		tone(8'h08, 16'h0000, s1);
		check({14'h0, s1}, {14'h0, s0});
		tone(8'h10, 16'h0000, s1);
		check({31'h0, near(s1, s0, 1)}, 32'h1);
		// One quarter-turn frequency step moves the phase; a sync then clears it
		tone(8'h04, 16'h0000, s1);
		acc(mk(1'b1, 1'b0, 2'h0, 4'h2, 32'h4000_0000));
		acc(mk(1'b1, 1'b0, 2'h0, 4'h2, 32'h0));
		acc('0);
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		s1 = wb_out;
		check({31'h0, near(s1, s0, 2)}, 32'h0);
		@(posedge mclk);
		sync_in <= 1'b1;
		@(posedge mclk);
		sync_in <= 1'b0;
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		s1 = wb_out;
		check({14'h0, s1}, {14'h0, s0});
		// Channel plus a near full-scale input overflows and wraps without clip
		sample <= 18'h1F800;
		repeat (5) @(posedge mclk);
		@(negedge mclk);
		check({14'h0, wb_out}, {14'h0, 18'(18'h1F800 + s0)});
		final_report;
	end

	// Watchdog well beyond the expected run length
	initial
	begin
		repeat (5000) @(posedge mclk);
		fail_count++;
		final_report;
	end
endmodule
`default_nettype wire
